// [rips_regs.svh]
`ifndef RIPS_REGS_SVH
`define RIPS_REGS_SVH
// byte addresses on the register bus
`define RIPS_OFF_SEL0 12'h000
`define RIPS_OFF_SEL1 12'h004
`define RIPS_OFF_SEL2 12'h008
`define RIPS_OFF_SEL3 12'h00c
`define RIPS_OFF_SEL4 12'h010
`define RIPS_OFF_SEL7 12'h01c
`define RIPS_OFF_SEL8 12'h020
`define RIPS_OFF_OSC 12'h040
// field positions
`define RIPS_HI_LSB 8
`define RIPS_LO_LSB 0
`define RIPS_SEL_W 6
`define RIPS_LOCK_BIT 6
`define RIPS_ONEWAY_BIT 5
// reset values and keys
`define RIPS_SEL_RST 6'h3f
`define RIPS_KEY1 8'h46
`define RIPS_KEY2 8'h57
// number of remappable pin inputs (selector codes 0..count-1)
`define RIPS_PIN_COUNT 44
`define RIPS_NSEL 13
// axi answers
`define RIPS_RESP_OKAY 2'h0
`define RIPS_RESP_SLVERR 2'h2
`endif

// [rips_pkg.sv]
package rips_pkg;
    typedef logic [5:0] rips_sel_type;
    typedef struct packed {
        logic [3:0] ext_int;
        logic [1:0] cmp_trig;
        logic [3:0] timer_clk;
        logic [2:0] capture;
    } rips_periph_type;
    typedef enum logic [1:0] {
        RIPS_KEY_IDLE,
        RIPS_KEY_ONE,
        RIPS_KEY_OPEN
    } rips_key_type;
endpackage

// [rips_pin_mux.sv]
`timescale 1ns/10ps
`include "rips_regs.svh"
module rips_pin_mux (
    input wire logic [63:0] pins,
    input wire logic [63:0] pin_present,
    input wire rips_pkg::rips_sel_type sel,
    output logic level
);
    import rips_pkg::*;
    wire sel_valid = (sel != `RIPS_SEL_RST) && pin_present[sel];
    assign level = sel_valid ? pins[sel] : 1'b0;
endmodule // rips_pin_mux

// [rips_input_select.sv]
`timescale 1ns/10ps
`include "rips_regs.svh"
// Behaviour
// - selector writes only while lock bit clear
// - seven input routing registers holding thirteen selectors
// - six-bit selector names driving pin
// - two bits above each field read zero
// - first register: int1 upper, trigger1 lower
// - int3/int2 and trigger2/int4 register pairs
// - timer3/timer2 and timer5/timer4 clock selectors
// - capture2/capture1; capture3 alone, low bits
// - lock change only after 46h, 57h keys
// - lock resets unlocked, holds until changed
// - one-way option blocks clearing until reset
// - unimplemented pin selection is invalid
module rips_input_select (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic one_way_lock_config_bit,
    input wire logic [63:0] pin_present,
    input wire logic [`RIPS_PIN_COUNT-1:0] remappable_io_pin,
    output rips_pkg::rips_periph_type periph_in,
    output logic mapping_lock_bit,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import rips_pkg::*;

    // selector index: 0 int1,1 int2,2 int3,3 int4,4 trig1,5 trig2,
    // 6..9 timer2..5 clk,10..12 capture1..3
    rips_sel_type sel_r [`RIPS_NSEL];
    logic lock_r;
    logic oneway_seen_r;
    rips_key_type key_r;
    logic [11:0] awaddr_r;
    logic aw_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_have_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    // only the input routing registers and the lock register of this block are decoded
    function automatic logic known_addr(input logic [11:0] a);
        case (a)
            `RIPS_OFF_SEL0, `RIPS_OFF_SEL1, `RIPS_OFF_SEL2, `RIPS_OFF_SEL3,
            `RIPS_OFF_SEL4, `RIPS_OFF_SEL7, `RIPS_OFF_SEL8,
            `RIPS_OFF_OSC: known_addr = 1'b1;
            default: known_addr = 1'b0;
        endcase
    endfunction

    // selector pair packed into a word; bits above each field read zero
    function automatic logic [31:0] pair_word(input rips_sel_type hi, input rips_sel_type lo);
        pair_word = {16'h0000, 2'b00, hi, 2'b00, lo};
    endfunction

    // register read mux
    logic [31:0] rd_word;
    always_comb begin
        case (s_axi_araddr)
            `RIPS_OFF_SEL0: rd_word = pair_word(sel_r[0], sel_r[4]);
            `RIPS_OFF_SEL1: rd_word = pair_word(sel_r[2], sel_r[1]);
            `RIPS_OFF_SEL2: rd_word = pair_word(sel_r[5], sel_r[3]);
            `RIPS_OFF_SEL3: rd_word = pair_word(sel_r[7], sel_r[6]);
            `RIPS_OFF_SEL4: rd_word = pair_word(sel_r[9], sel_r[8]);
            `RIPS_OFF_SEL7: rd_word = pair_word(sel_r[11], sel_r[10]);
            `RIPS_OFF_SEL8: rd_word = pair_word(6'h00, sel_r[12]);
            `RIPS_OFF_OSC: rd_word = {25'h0, lock_r, 6'h00};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // write channel: address and data taken in either order, held until response
    wire aw_take = s_axi_awvalid && !aw_have_r && !bvalid_r;
    wire w_take = s_axi_wvalid && !w_have_r && !bvalid_r;
    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready = !w_have_r && !bvalid_r;
    wire [11:0] wr_addr = aw_have_r ? awaddr_r : s_axi_awaddr;
    wire [31:0] wr_data = w_have_r ? wdata_r : s_axi_wdata;
    wire [3:0] wr_strb = w_have_r ? wstrb_r : s_axi_wstrb;
    wire wr_go = (aw_have_r || aw_take) && (w_have_r || w_take);
    wire wr_known = known_addr(wr_addr);

    wire sel_wr_ok = wr_go && !lock_r;
    wire osc_wr = wr_go && (wr_addr == `RIPS_OFF_OSC) && wr_strb[0];
    wire [7:0] osc_byte = wr_data[7:0];
    wire lock_req = osc_byte[`RIPS_LOCK_BIT];
    // keys seen back to back; any other write to the byte restarts the sequence
    wire keys_open = (key_r == RIPS_KEY_OPEN);
    wire clear_blocked = one_way_lock_config_bit && oneway_seen_r;
    wire lock_change = osc_wr && keys_open && (osc_byte != `RIPS_KEY1)
        && !(lock_r && !lock_req && clear_blocked);

    rips_key_type key_nxt;
    always_comb begin
        key_nxt = key_r;
        if (osc_wr) begin
            case (key_r)
                RIPS_KEY_IDLE: key_nxt = (osc_byte == `RIPS_KEY1) ? RIPS_KEY_ONE : RIPS_KEY_IDLE;
                RIPS_KEY_ONE: key_nxt = (osc_byte == `RIPS_KEY2) ? RIPS_KEY_OPEN
                    : ((osc_byte == `RIPS_KEY1) ? RIPS_KEY_ONE : RIPS_KEY_IDLE);
                RIPS_KEY_OPEN: key_nxt = (osc_byte == `RIPS_KEY1) ? RIPS_KEY_ONE : RIPS_KEY_IDLE;
                default: key_nxt = RIPS_KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            key_r <= RIPS_KEY_IDLE;
            lock_r <= 1'b0;
            oneway_seen_r <= 1'b0;
        end else if (clk_en) begin
            key_r <= key_nxt;
            if (lock_change) begin
                lock_r <= lock_req;
            end
            if (lock_change && lock_req) begin
                oneway_seen_r <= 1'b1;
            end
        end
    end

    // per-selector write decode: address and byte lane of each field
    function automatic logic [11:0] sel_addr(input int i);
        case (i)
            0, 4: sel_addr = `RIPS_OFF_SEL0;
            1, 2: sel_addr = `RIPS_OFF_SEL1;
            3, 5: sel_addr = `RIPS_OFF_SEL2;
            6, 7: sel_addr = `RIPS_OFF_SEL3;
            8, 9: sel_addr = `RIPS_OFF_SEL4;
            10, 11: sel_addr = `RIPS_OFF_SEL7;
            default: sel_addr = `RIPS_OFF_SEL8;
        endcase
    endfunction

    function automatic logic sel_upper(input int i);
        sel_upper = (i == 0) || (i == 2) || (i == 5) || (i == 7) || (i == 9) || (i == 11);
    endfunction

    genvar g;
    generate
        for (g = 0; g < `RIPS_NSEL; g++) begin : g_sel
            wire hit = sel_wr_ok && (wr_addr == sel_addr(g))
                && (sel_upper(g) ? wr_strb[1] : wr_strb[0]);
            wire [5:0] field = sel_upper(g) ? wr_data[`RIPS_HI_LSB +: `RIPS_SEL_W]
                : wr_data[`RIPS_LO_LSB +: `RIPS_SEL_W];
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sel_r[g] <= `RIPS_SEL_RST;
                end else if (clk_en && hit) begin
                    sel_r[g] <= field;
                end
            end
        end
    endgenerate

    // bus state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= `RIPS_RESP_OKAY;
        end else if (clk_en) begin
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                bvalid_r <= 1'b1;
                // locked writes look normal; only unmapped addresses error
                bresp_r <= wr_known ? `RIPS_RESP_OKAY : `RIPS_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_have_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_have_r <= 1'b1;
                    wdata_r <= s_axi_wdata;
                    wstrb_r <= s_axi_wstrb;
                end
                if (bvalid_r && s_axi_bready) begin
                    bvalid_r <= 1'b0;
                end
            end
        end
    end

    assign s_axi_arready = !rvalid_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= `RIPS_RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= known_addr(s_axi_araddr) ? `RIPS_RESP_OKAY : `RIPS_RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign mapping_lock_bit = lock_r;

    // routing muxes; absent pins are masked invalid
    wire [63:0] pins_wide = {{(64 - `RIPS_PIN_COUNT){1'b0}}, remappable_io_pin};
    wire [63:0] present_eff = pin_present & {{(64 - `RIPS_PIN_COUNT){1'b0}},
        {`RIPS_PIN_COUNT{1'b1}}};
    logic [`RIPS_NSEL-1:0] routed;
    generate
        for (g = 0; g < `RIPS_NSEL; g++) begin : g_mux
            rips_pin_mux u_mux (
                .pins(pins_wide),
                .pin_present(present_eff),
                .sel(sel_r[g]),
                .level(routed[g])
            );
        end
    endgenerate

    logic [`RIPS_NSEL-1:0] periph_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_r <= '0;
        end else if (clk_en) begin
            periph_r <= routed;
        end
    end

    assign periph_in = rips_periph_type'({periph_r[3:0], periph_r[5:4],
        periph_r[9:6], periph_r[12:10]});
endmodule // rips_input_select

// [rips_pin_src.sv]
`timescale 1ns/10ps
`include "rips_regs.svh"
module rips_pin_src (
    input wire logic aclk,
    input wire logic [6:0] hot,
    output logic [`RIPS_PIN_COUNT-1:0] pins
);
    // one pin high at a time, any index past the pins keeps all low
    always_ff @(posedge aclk) begin
        pins <= `RIPS_PIN_COUNT'(64'h1 << hot);
    end
endmodule // rips_pin_src

// [rips_input_select_checker.sv]
`timescale 1ns/10ps
`include "rips_regs.svh"
module rips_input_select_checker import rips_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic one_way_lock_config_bit,
    input wire logic [`RIPS_PIN_COUNT-1:0] remappable_io_pin,
    input wire rips_periph_type periph_in,
    input wire logic mapping_lock_bit,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
    endsequence
    a_lock_reset: assert property ($rose(aresetn) |-> !mapping_lock_bit)
        else $error("lock not clear after reset");
    a_lock_cause: assert property (!$stable(mapping_lock_bit) |-> s_axi_bvalid)
        else $error("lock moved without a write");
    a_one_way: assert property (one_way_lock_config_bit && mapping_lock_bit |=> mapping_lock_bit)
        else $error("one way lock cleared");
    a_pins_low: assert property (remappable_io_pin == '0 |=> periph_in == '0)
        else $error("peripheral input high with all pins low");
    a_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0)
        else $error("unimplemented bits read nonzero");
    a_write_resp: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write answer late");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid)
        else $error("read answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule // rips_input_select_checker

bind rips_input_select rips_input_select_checker chk (.aclk, .aresetn, .clk_en,
    .one_way_lock_config_bit, .remappable_io_pin, .periph_in, .mapping_lock_bit,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready);

// [tb_top.sv]
`timescale 1ns/10ps
module tb_top;
    import rips_pkg::*;
    logic aclk, aresetn, clk_en, one_way_lock_config_bit, mapping_lock_bit;
    logic [63:0] pin_present;
    logic [43:0] remappable_io_pin;
    logic [6:0] hot;
    rips_periph_type periph_in;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp_val;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fails = 0, checks_done = 0;
    logic [11:0] ra[7] = '{12'h0, 12'h4, 12'h8, 12'hc, 12'h10, 12'h1c, 12'h20};
    int hb[7] = '{9, 11, 8, 4, 6, 1, -1};
    int lb[7] = '{7, 10, 12, 3, 5, 0, 2};
    int e;
    rips_input_select DUT (.*);
    rips_pin_src src (.aclk(aclk), .hot(hot), .pins(remappable_io_pin));
    initial begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic print_verdict();
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // one bus transfer, write when w is high; each channel released when taken
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic aw_rdy, w_rdy, ar_rdy, b_v, r_v;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        do begin
            // settled values stand unchanged up to the next rising edge
            @(negedge aclk);
            if (s_axi_bvalid && s_axi_bready) resp_val = s_axi_bresp;
            if (s_axi_rvalid && s_axi_rready) {rd_val, resp_val} = {s_axi_rdata, s_axi_rresp};
            aw_rdy = s_axi_awready && s_axi_awvalid;
            w_rdy = s_axi_wready && s_axi_wvalid;
            ar_rdy = s_axi_arready && s_axi_arvalid;
            b_v = s_axi_bvalid && s_axi_bready;
            r_v = s_axi_rvalid && s_axi_rready;
            @(posedge aclk);
            if (aw_rdy) s_axi_awvalid <= 1'b0;
            if (w_rdy) s_axi_wvalid <= 1'b0;
            if (ar_rdy) s_axi_arvalid <= 1'b0;
            if (b_v) s_axi_bready <= 1'b0;
            if (r_v) s_axi_rready <= 1'b0;
        end while (!(b_v || r_v));
    endtask
    task automatic key(input logic [31:0] v);
        acc(1, 12'h40, 32'h46);
        acc(1, 12'h40, 32'h57);
        acc(1, 12'h40, v);
    endtask
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
    initial begin
        {aresetn, one_way_lock_config_bit, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
        {clk_en, pin_present, hot, s_axi_wstrb} = {1'b1, 64'hffffffffffffffff, 7'h7f, 4'hf};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            acc(0, ra[i], 0);
            chk("reset value", i == 6 ? 32'h3f : 32'h3f3f, rd_val);
            acc(1, ra[i], 32'hffffffff);
            acc(0, ra[i], 0);
            chk("unused bits", i == 6 ? 32'h3f : 32'h3f3f, rd_val);
            acc(1, ra[i], {18'h0, 6'(2 * i + 1), 2'b0, 6'(2 * i + 2)});
        end
        // pin p routes to the field it was written into; the missing upper field routes none
        for (int i = 0; i < 14; i++) begin
            @(posedge aclk);
            hot <= 7'(i + 1);
            repeat (3) @(negedge aclk);
            e = (i % 2 == 0) ? hb[i / 2] : lb[i / 2];
            chk("routing", e < 0 ? 0 : 32'h1 << e, 32'(periph_in));
        end
        @(posedge aclk);
        pin_present <= ~64'h2;
        hot <= 7'd1;
        repeat (3) @(negedge aclk);
        chk("absent pin", 0, 32'(periph_in));
        acc(0, 12'h100, 0);
        chk("unmapped resp", 2, 32'(resp_val));
        chk("unmapped data", 0, rd_val);
        key(32'h40);
        chk("lock set", 1, 32'(mapping_lock_bit));
        acc(0, 12'h40, 0);
        chk("lock read", 32'h40, rd_val & 32'h40);
        acc(1, 12'h0, 0);
        chk("locked write resp", 0, 32'(resp_val));
        acc(0, 12'h0, 0);
        chk("locked write", 32'h0102, rd_val);
        acc(1, 12'h40, 0);
        chk("keyless clear", 1, 32'(mapping_lock_bit));
        key(0);
        chk("lock clear", 0, 32'(mapping_lock_bit));
        one_way_lock_config_bit <= 1'b1;
        key(32'h40);
        key(0);
        chk("one way", 1, 32'(mapping_lock_bit));
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        {aresetn, one_way_lock_config_bit} <= 2'b10;
        @(negedge aclk);
        chk("lock after reset", 0, 32'(mapping_lock_bit));
        acc(0, 12'h0, 0);
        chk("sel after reset", 32'h3f3f, rd_val);
        print_verdict();
    end
endmodule // tb_top
